//--- pkg/rsl_pkg.sv
// Package: constants for the RS-485 slave serial link
package rsl_pkg;
  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ = 40000000;
  localparam logic [2:0] BAUD_RST = 3'h2;
  localparam logic [2:0] FMT_RST = 3'h1;
  localparam logic signed [6:0] STATION_RST = 7'sh01;
  localparam logic signed [6:0] STATION_OFF = -7'sh01;
  localparam logic signed [6:0] STATION_MAX = 7'sh20;
  localparam int DATA_BITS = 8;
  // Bit periods in core cycles, rounded down
  localparam int unsigned BAUD_4800 = 4800;
  localparam int unsigned BAUD_9600 = 9600;
  localparam int unsigned BAUD_19200 = 19200;
  localparam int unsigned BAUD_38400 = 38400;
  localparam int unsigned BAUD_57600 = 57600;
  localparam int unsigned BAUD_115200 = 115200;
  localparam logic [13:0] DIV_0 = 14'(CLK_HZ / BAUD_4800);
  localparam logic [13:0] DIV_1 = 14'(CLK_HZ / BAUD_9600);
  localparam logic [13:0] DIV_2 = 14'(CLK_HZ / BAUD_19200);
  localparam logic [13:0] DIV_3 = 14'(CLK_HZ / BAUD_38400);
  localparam logic [13:0] DIV_4 = 14'(CLK_HZ / BAUD_57600);
  localparam logic [13:0] DIV_5 = 14'(CLK_HZ / BAUD_115200);
  // Inter-frame silence of 40 bit periods, whatever the character length
  localparam logic [7:0] GAP_BITS = 8'h28;
  localparam int FIFO_DEPTH = 32;

  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP}
    rsl_rx_t;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP}
    rsl_tx_t;
endpackage : rsl_pkg

//--- rtl/rsl_fifo.sv
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module rsl_fifo
  import rsl_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = FIFO_DEPTH
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData,
  // Flush
  input wire logic flush
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
  logic [AW:0] count_q, count_d;
  logic push, pop;

  assign inReady = (count_q != (AW+1)'(DEPTH));
  assign outValid = (count_q != '0);
  assign outData = mem[rdPtr_q];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_comb
  begin
    wrPtr_d = wrPtr_q;
    rdPtr_d = rdPtr_q;
    count_d = count_q;
    if (flush)
    begin
      wrPtr_d = '0;
      rdPtr_d = '0;
      count_d = '0;
    end
    else
    begin
      if (push)
        wrPtr_d = wrPtr_q + 1'b1;
      if (pop)
        rdPtr_d = rdPtr_q + 1'b1;
      if (push && !pop)
        count_d = count_q + 1'b1;
      else if (pop && !push)
        count_d = count_q - 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end
    else
    begin
      wrPtr_q <= wrPtr_d;
      rdPtr_q <= rdPtr_d;
      count_q <= count_d;
    end
  end

  // Storage has no reset; contents only matter below count
  always_ff @(posedge core_clk)
  begin
    if (push && !flush)
      mem[wrPtr_q] <= inData;
  end

  property p_no_overflow;
    @(posedge core_clk) disable iff (!rst_n)
      count_q <= (AW+1)'(DEPTH);
  endproperty
  a_no_overflow: assert property (p_no_overflow)
    else $error("FIFO count above depth");
endmodule : rsl_fifo

//--- rtl/rsl_link.sv
// RS-485 slave serial link: configurable RTU character engine
`timescale 1ns/1ps
module rsl_link
  import rsl_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Configuration
  input wire logic signed [6:0] stationId,
  input wire logic [2:0] baudCode,
  input wire logic [2:0] frameFmt,
  // Bus line
  input wire logic rxd,
  output logic txd,
  output logic txOe,
  // Received request bytes
  output logic rxValid,
  input wire logic rxReady,
  output logic [7:0] rxData,
  output logic rxFrameEnd,
  // Reply bytes
  input wire logic txValid,
  output logic txReady,
  input wire logic [7:0] txData,
  // Status
  output logic linkEnabled,
  output logic parityErr,
  output logic framingErr
);
  // ----------------------------------------
  // Configuration decode
  // ----------------------------------------
  function automatic logic [13:0] baudDiv(input logic [2:0] code);
    case (code)
      3'h0: baudDiv = DIV_0;
      3'h1: baudDiv = DIV_1;
      3'h2: baudDiv = DIV_2;
      3'h3: baudDiv = DIV_3;
      3'h4: baudDiv = DIV_4;
      default: baudDiv = DIV_5;
    endcase
  endfunction : baudDiv

  logic [13:0] divTop;
  logic parOn, parOdd, twoStop;
  assign divTop = baudDiv(baudCode);
  assign parOn = (frameFmt != 3'h0) && (frameFmt != 3'h3);
  assign parOdd = (frameFmt == 3'h2) || (frameFmt == 3'h5);
  assign twoStop = (frameFmt >= 3'h3);
  // Zero is outside the range; treated as disabled as well
  assign linkEnabled = (stationId > 7'sh00) && (stationId <= STATION_MAX);

  // ----------------------------------------
  // Receiver
  // ----------------------------------------
  rsl_rx_t rxSt_q, rxSt_d;
  logic [13:0] rxCnt_q, rxCnt_d;
  logic [2:0] rxBit_q, rxBit_d;
  logic [7:0] rxSh_q, rxSh_d;
  logic rxPar_q, rxPar_d;
  logic [7:0] gap_q, gap_d;
  logic [13:0] gapCnt_q, gapCnt_d;
  logic inFrame_q, inFrame_d, firstByte_q, firstByte_d;
  logic match_q, match_d, frameEnd_q, frameEnd_d;
  logic parErr_q, parErr_d, frmErr_q, frmErr_d;
  logic byteDone, fifoInReady;

  always_comb
  begin
    rxSt_d = rxSt_q;
    rxCnt_d = rxCnt_q;
    rxBit_d = rxBit_q;
    rxSh_d = rxSh_q;
    rxPar_d = rxPar_q;
    parErr_d = 1'b0;
    frmErr_d = 1'b0;
    byteDone = 1'b0;
    case (rxSt_q)
      RX_IDLE:
        if (!rxd && linkEnabled)
        begin
          rxSt_d = RX_START;
          rxCnt_d = {1'b0, divTop[13:1]};
        end
      RX_START:
        if (rxCnt_q == '0)
        begin
          rxSt_d = rxd ? RX_IDLE : RX_DATA;
          rxCnt_d = divTop;
          rxBit_d = '0;
          rxPar_d = parOdd;
        end
        else
          rxCnt_d = rxCnt_q - 1'b1;
      RX_DATA:
        if (rxCnt_q == '0)
        begin
          rxSh_d = {rxd, rxSh_q[7:1]};
          rxPar_d = rxPar_q ^ rxd;
          rxCnt_d = divTop;
          rxBit_d = rxBit_q + 1'b1;
          if (rxBit_q == 3'(DATA_BITS - 1))
            rxSt_d = parOn ? RX_PAR : RX_STOP;
        end
        else
          rxCnt_d = rxCnt_q - 1'b1;
      RX_PAR:
        if (rxCnt_q == '0)
        begin
          parErr_d = (rxPar_q ^ rxd);
          // Running sum turns into the error flag for the stop state
          rxPar_d = rxPar_q ^ rxd;
          rxCnt_d = divTop;
          rxSt_d = RX_STOP;
        end
        else
          rxCnt_d = rxCnt_q - 1'b1;
      RX_STOP:
        // Only the first stop bit is checked; a second is idle anyway
        if (rxCnt_q == '0)
        begin
          frmErr_d = !rxd;
          byteDone = rxd;
          rxSt_d = RX_IDLE;
        end
        else
          rxCnt_d = rxCnt_q - 1'b1;
      default:
        rxSt_d = RX_IDLE;
    endcase
  end

  // ----------------------------------------
  // RTU framing: silence delimits, first byte is address
  // ----------------------------------------
  logic busy;
  assign busy = (rxSt_q != RX_IDLE) || !rxd;

  always_comb
  begin
    gap_d = gap_q;
    gapCnt_d = gapCnt_q;
    inFrame_d = inFrame_q;
    firstByte_d = firstByte_q;
    match_d = match_q;
    frameEnd_d = 1'b0;
    if (busy)
    begin
      gap_d = '0;
      gapCnt_d = divTop;
    end
    else if (gapCnt_q != '0)
      gapCnt_d = gapCnt_q - 1'b1;
    else if (gap_q != GAP_BITS)
    begin
      gapCnt_d = divTop;
      gap_d = gap_q + 1'b1;
    end
    if (!busy && gapCnt_q == '0 && gap_q == GAP_BITS - 8'h01)
    begin
      frameEnd_d = inFrame_q && match_q;
      inFrame_d = 1'b0;
      firstByte_d = 1'b1;
    end
    if (byteDone)
    begin
      inFrame_d = 1'b1;
      firstByte_d = 1'b0;
      if (firstByte_q)
        match_d = (rxSh_q == 8'(stationId[5:0]));
    end
  end

  logic wantByte;
  logic [7:0] rxByte;
  assign rxByte = rxSh_q;
  // Address byte is matched before it is queued
  assign wantByte = byteDone && !(parOn && rxPar_q) && (firstByte_q ?
    (rxSh_q == 8'(stationId[5:0])) : match_q);

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rxSt_q <= RX_IDLE;
      rxCnt_q <= '0;
      rxBit_q <= '0;
      rxSh_q <= '0;
      rxPar_q <= 1'b0;
      gap_q <= '0;
      gapCnt_q <= '0;
      inFrame_q <= 1'b0;
      firstByte_q <= 1'b1;
      match_q <= 1'b0;
      frameEnd_q <= 1'b0;
      parErr_q <= 1'b0;
      frmErr_q <= 1'b0;
    end
    else
    begin
      rxSt_q <= rxSt_d;
      rxCnt_q <= rxCnt_d;
      rxBit_q <= rxBit_d;
      rxSh_q <= rxSh_d;
      rxPar_q <= rxPar_d;
      gap_q <= gap_d;
      gapCnt_q <= gapCnt_d;
      inFrame_q <= inFrame_d;
      firstByte_q <= firstByte_d;
      match_q <= match_d;
      frameEnd_q <= frameEnd_d;
      parErr_q <= parErr_d;
      frmErr_q <= frmErr_d;
    end
  end

  assign rxFrameEnd = frameEnd_q;
  assign parityErr = parErr_q;
  assign framingErr = frmErr_q;

  // Overflowing bytes are dropped; the frame check upstream catches it
  rsl_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_rxFifo (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .inValid(wantByte),
    .inReady(fifoInReady),
    .inData(rxByte),
    .outValid(rxValid),
    .outReady(rxReady),
    .outData(rxData),
    .flush(!linkEnabled)
  );

  // ----------------------------------------
  // Transmitter: answers only an addressed request
  // ----------------------------------------
  rsl_tx_t txSt_q, txSt_d;
  logic [13:0] txCnt_q, txCnt_d;
  logic [2:0] txBit_q, txBit_d;
  logic [7:0] txSh_q, txSh_d;
  logic txPar_q, txPar_d, txLine_q, txLine_d, stop2_q, stop2_d;
  logic replyOk_q, replyOk_d;

  assign txReady = (txSt_q == TX_IDLE) && replyOk_q && linkEnabled;

  always_comb
  begin
    txSt_d = txSt_q;
    txCnt_d = txCnt_q;
    txBit_d = txBit_q;
    txSh_d = txSh_q;
    txPar_d = txPar_q;
    txLine_d = txLine_q;
    stop2_d = stop2_q;
    replyOk_d = replyOk_q;
    if (frameEnd_q)
      replyOk_d = 1'b1;
    else if (byteDone || !linkEnabled)
      replyOk_d = 1'b0;
    case (txSt_q)
      TX_IDLE:
      begin
        txLine_d = 1'b1;
        if (txValid && txReady)
        begin
          txSh_d = txData;
          txPar_d = parOdd;
          txLine_d = 1'b0;
          txCnt_d = divTop;
          txSt_d = TX_START;
        end
      end
      TX_START, TX_DATA, TX_PAR, TX_STOP:
        if (txCnt_q != '0)
          txCnt_d = txCnt_q - 1'b1;
        else
        begin
          txCnt_d = divTop;
          if (txSt_q == TX_START || (txSt_q == TX_DATA && txBit_q != 3'h0))
          begin
            txSt_d = TX_DATA;
            txLine_d = txSh_q[0];
            txPar_d = txPar_q ^ txSh_q[0];
            txSh_d = {1'b0, txSh_q[7:1]};
            txBit_d = txBit_q + 1'b1;
          end
          else if (txSt_q == TX_DATA && parOn)
          begin
            txSt_d = TX_PAR;
            txLine_d = txPar_q;
          end
          else if (txSt_q != TX_STOP)
          begin
            txSt_d = TX_STOP;
            txLine_d = 1'b1;
            stop2_d = twoStop;
          end
          else if (stop2_q)
            stop2_d = 1'b0;
          else
            txSt_d = TX_IDLE;
        end
      default:
        txSt_d = TX_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      txSt_q <= TX_IDLE;
      txCnt_q <= '0;
      txBit_q <= '0;
      txSh_q <= '0;
      txPar_q <= 1'b0;
      txLine_q <= 1'b1;
      stop2_q <= 1'b0;
      replyOk_q <= 1'b0;
    end
    else
    begin
      txSt_q <= txSt_d;
      txCnt_q <= txCnt_d;
      txBit_q <= txBit_d;
      txSh_q <= txSh_d;
      txPar_q <= txPar_d;
      txLine_q <= txLine_d;
      stop2_q <= stop2_d;
      replyOk_q <= replyOk_d;
    end
  end

  assign txd = txLine_q;
  assign txOe = (txSt_q != TX_IDLE);

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_disabled_quiet;
    @(posedge core_clk) disable iff (!rst_n)
      !linkEnabled && txSt_q == TX_IDLE |=> !txOe;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet)
    else $error("Driver enabled while link disabled");

  property p_no_unsolicited;
    @(posedge core_clk) disable iff (!rst_n)
      $rose(txOe) |-> $past(replyOk_q);
  endproperty
  a_no_unsolicited: assert property (p_no_unsolicited)
    else $error("Transmission without prior addressed request");

  property p_addr_match;
    @(posedge core_clk) disable iff (!rst_n)
      byteDone && firstByte_q |=> match_q == (rxSh_q == 8'(stationId[5:0]));
  endproperty
  a_addr_match: assert property (p_addr_match)
    else $error("Address match flag wrong");

  property p_start_len;
    @(posedge core_clk) disable iff (!rst_n)
      $rose(txOe) |-> !txd [*8];
  endproperty
  a_start_len: assert property (p_start_len)
    else $error("Start bit too short");

  property p_par_state;
    @(posedge core_clk) disable iff (!rst_n)
      txSt_q == TX_PAR |-> parOn;
  endproperty
  a_par_state: assert property (p_par_state)
    else $error("Parity bit sent with parity off");

  property p_stop_high;
    @(posedge core_clk) disable iff (!rst_n)
      txSt_q == TX_STOP |-> txd;
  endproperty
  a_stop_high: assert property (p_stop_high)
    else $error("Stop bit not high");

  property p_frame_end_match;
    @(posedge core_clk) disable iff (!rst_n)
      rxFrameEnd |-> $past(match_q);
  endproperty
  a_frame_end_match: assert property (p_frame_end_match)
    else $error("Frame end reported for foreign frame");

  property p_foreign_dropped;
    @(posedge core_clk) disable iff (!rst_n)
      byteDone && !firstByte_q && !match_q |-> !wantByte;
  endproperty
  a_foreign_dropped: assert property (p_foreign_dropped)
    else $error("Foreign byte queued");

  c_frame_end: cover property (@(posedge core_clk) rxFrameEnd);
  c_reply: cover property (@(posedge core_clk) $rose(txOe));
  c_par_err: cover property (@(posedge core_clk) parityErr);
  c_two_stop: cover property (@(posedge core_clk) txSt_q == TX_STOP && stop2_q);
endmodule : rsl_link

//--- tb/rsl_master_model.sv
// Upper controller model: sends request bytes, samples reply bytes
`timescale 1ns/1ps
module rsl_master_model
  import rsl_pkg::*;
#(
  parameter int BIT_CYC = 348
)
(
  // Clock
  input wire logic core_clk,
  // Line
  output logic rxd,
  input wire logic txd,
  input wire logic txOe,
  // Character format shared with the slave
  input wire logic [2:0] fmt
);
  // ----------------------------------------
  // Character timing
  // ----------------------------------------
  // Biased bus idles high between characters
  initial rxd = 1'b1;

  function automatic logic par(input logic [7:0] d);
    return (fmt == 3'h2 || fmt == 3'h5) ? ~^d : ^d;
  endfunction : par

  task automatic hold_bit(input logic b);
    rxd = b;
    repeat (BIT_CYC) @(negedge core_clk);
  endtask : hold_bit

  // Only this side ever opens an exchange
  task automatic send_char(input logic [7:0] d, input logic flip);
    @(negedge core_clk);
    hold_bit(1'b0);
    for (int i = 0; i < 8; i++)
      hold_bit(d[i]);
    if (fmt != 3'h0 && fmt != 3'h3)
      hold_bit(par(d) ^ flip);
    hold_bit(1'b1);
    if (fmt >= 3'h3)
      hold_bit(1'b1);
  endtask : send_char

  // Mid-bit sampling; a slow slave fails the start check
  task automatic get_char(output logic [7:0] d, output logic ok);
    int n;
    ok = 1'b1;
    n = 0;
    d = 8'h00;
    while (txOe !== 1'b1 && n < 20 * BIT_CYC)
    begin
      @(negedge core_clk);
      n++;
    end
    repeat (BIT_CYC / 2) @(negedge core_clk);
    if (txd !== 1'b0 || txOe !== 1'b1)
      ok = 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      repeat (BIT_CYC) @(negedge core_clk);
      d[i] = txd;
    end
    if (fmt != 3'h0 && fmt != 3'h3)
    begin
      repeat (BIT_CYC) @(negedge core_clk);
      if (txd !== par(d))
        ok = 1'b0;
    end
    for (int s = 0; s < ((fmt >= 3'h3) ? 2 : 1); s++)
    begin
      repeat (BIT_CYC) @(negedge core_clk);
      if (txd !== 1'b1 || txOe !== 1'b1)
        ok = 1'b0;
    end
  endtask : get_char
endmodule : rsl_master_model

//--- tb/rs485_slave_link_config_bench.sv
// Self-checking bench for the slave serial link
`timescale 1ns/1ps
module rs485_slave_link_config_bench
  import rsl_pkg::*;
;
  localparam int BIT_CYC = int'(DIV_5) + 1;
  logic core_clk, rst_n, rxd, txd, txOe, rxValid, rxReady, rxFrameEnd;
  logic txValid, txReady, linkEnabled, parityErr, framingErr, ok;
  logic signed [6:0] stationId, st;
  logic signed [6:0] tbl [5];
  logic [2:0] baudCode, frameFmt;
  logic [7:0] rxData, txData, d1, d3;
  int errTotal, checkCount, feSeen, peSeen, oeSeen, frSeen;

  rsl_link DUT (.core_clk(core_clk), .rst_n(rst_n), .stationId(stationId),
    .baudCode(baudCode), .frameFmt(frameFmt), .rxd(rxd), .txd(txd),
    .txOe(txOe), .rxValid(rxValid), .rxReady(rxReady), .rxData(rxData),
    .rxFrameEnd(rxFrameEnd), .txValid(txValid), .txReady(txReady),
    .txData(txData), .linkEnabled(linkEnabled), .parityErr(parityErr),
    .framingErr(framingErr));
  rsl_master_model #(.BIT_CYC(BIT_CYC)) M (.core_clk(core_clk), .rxd(rxd),
    .txd(txd), .txOe(txOe), .fmt(frameFmt));

  // ----------------------------------------
  // Clock, monitors, helpers
  // ----------------------------------------
  initial core_clk = 1'b0;
  always #12.5 core_clk = ~core_clk;

  // Sampled away from the launching edge
  always @(negedge core_clk)
  begin
    feSeen += (rxFrameEnd === 1'b1);
    peSeen += (parityErr === 1'b1);
    frSeen += (framingErr === 1'b1);
    oeSeen += (txOe === 1'b1);
  end

  task automatic check(input string what, input logic [7:0] exp,
    input logic [7:0] got);
    checkCount++;
    if (got !== exp)
    begin
      errTotal++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic checkBit(input string what, input logic exp,
    input logic got);
    check(what, {7'h00, exp}, {7'h00, got});
  endtask : checkBit

  function automatic logic expEnabled(input logic signed [6:0] s);
    return (s > 7'sh00) && (s <= STATION_MAX);
  endfunction : expEnabled

  task automatic closeOut();
    $display("checks %0d mismatches %0d", checkCount, errTotal);
    if (errTotal == 0 && checkCount > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : closeOut

  // Stalls the FIFO until asked, then pops one byte
  task automatic popByte(input logic [7:0] exp);
    int n;
    n = 0;
    while (rxValid !== 1'b1 && n < 100)
    begin
      @(negedge core_clk);
      n++;
    end
    checkBit("rxValid", 1'b1, rxValid);
    check("rxData", exp, rxData);
    rxReady = 1'b1;
    @(negedge core_clk);
    rxReady = 1'b0;
  endtask : popByte

  // Silence long enough to close a frame, with margin
  task automatic waitGap();
    repeat (42 * BIT_CYC) @(negedge core_clk);
  endtask : waitGap

  task automatic reply(input logic [2:0] f);
    logic [7:0] d, got;
    logic gotOk;
    int n;
    frameFmt = f;
    d = 8'($urandom);
    n = 0;
    // Previous reply may still be in its last stop bit
    while (txReady !== 1'b1 && n < 2 * BIT_CYC)
    begin
      @(negedge core_clk);
      n++;
    end
    checkBit("txReady", 1'b1, txReady);
    txValid = 1'b1;
    txData = d;
    @(negedge core_clk);
    txValid = 1'b0;
    M.get_char(got, gotOk);
    checkBit("reply format", 1'b1, gotOk);
    check("reply byte", d, got);
  endtask : reply

  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  initial
  begin
    repeat (100000) @(posedge core_clk);
    errTotal++;
    $display("mismatch watchdog expected done seen hang");
    closeOut();
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial
  begin
    {feSeen, peSeen, frSeen, oeSeen, errTotal, checkCount} = '0;
    rst_n = 1'b0;
    stationId = STATION_RST;
    baudCode = 3'h5;
    frameFmt = FMT_RST;
    rxReady = 1'b0;
    txValid = 1'b0;
    txData = 8'h00;
    void'($urandom(10));
    repeat (4) @(negedge core_clk);
    checkBit("txOe in reset", 1'b0, txOe);
    rst_n = 1'b1;
    tbl = '{STATION_OFF, 7'sh00, 7'sh01, STATION_MAX, 7'sh00};
    tbl[4] = 7'($urandom_range(32, 1));
    for (int i = 0; i < 5; i++)
    begin
      stationId = tbl[i];
      @(negedge core_clk);
      checkBit("linkEnabled", expEnabled(tbl[i]), linkEnabled);
    end
    st = 7'($urandom_range(32, 1));
    stationId = st;
    // Addressed request, even parity, host stalling the FIFO
    d1 = 8'($urandom);
    M.send_char(8'(st), 1'b0);
    M.send_char(d1, 1'b0);
    popByte(8'(st));
    popByte(d1);
    waitGap();
    check("frame end", 8'h01, 8'(feSeen));
    for (int f = 0; f < 6; f++)
      reply(3'(f));
    // Foreign address: no store, no reply, no drive
    // Let the last reply's stop bits finish before counting drive
    repeat (BIT_CYC) @(negedge core_clk);
    frameFmt = 3'h3;
    oeSeen = 0;
    M.send_char(8'((st == STATION_MAX) ? 7'sh01 : st + 7'sh01), 1'b0);
    waitGap();
    checkBit("foreign rxValid", 1'b0, rxValid);
    check("foreign txOe", 8'h00, 8'(oeSeen));
    check("foreign end", 8'h01, 8'(feSeen));
    checkBit("foreign txReady", 1'b0, txReady);
    // Odd parity, bad middle byte is dropped
    frameFmt = 3'h5;
    d3 = 8'($urandom);
    M.send_char(8'(st), 1'b0);
    M.send_char(8'($urandom), 1'b1);
    M.send_char(d3, 1'b0);
    check("parityErr", 8'h01, 8'(peSeen));
    popByte(8'(st));
    popByte(d3);
    checkBit("rxValid drained", 1'b0, rxValid);
    waitGap();
    check("frame end", 8'h02, 8'(feSeen));
    check("framingErr", 8'h00, 8'(frSeen));
    closeOut();
  end
endmodule : rs485_slave_link_config_bench
